// ==== adcp_host.sv ====
// Host controller driving the eight-channel converter through its parallel pins.
// Assumes all device pins are synchronous to clock_in and the data pins are driven
// by the device at all times, carrying the result only while chip select and read strobe are both low.
// Contract
// R1 - The device pulls end-of-conversion low when a new result sits in its output register.
// R2 - That low pulse lasts at most 110 ns unless ended earlier.
// R3 - A rising read strobe ends the end-of-conversion pulse early.
// R4 - The result is read while chip select and read strobe are both low.
// R5 - The host may hold chip select low and use the read strobe alone.
// R6 - A logic host may feed the end-of-conversion pulse onto chip select and read strobe.
// R7 - The host may treat the falling end-of-conversion edge as a data-ready event.
// R8 - The device latches the channel address on the falling read strobe.
// R9 - Chip select is derived without using the channel address lines.
// R10 - A falling convert strobe puts the track-and-hold into hold and starts a conversion.
// R11 - The channel latched at a read selects input n+1 for the next conversion; here latched channel n is the input converted and reported.
// R12 - The convert strobe level at the end-of-conversion rise picks power-down or not.
// R13 - A rising convert strobe wakes the converter; reads work while powered down.
// R14 - The device floats its data pins when chip select or read strobe is high; adcp_dev drives the inverted result there instead.
`timescale 1ns/100ps
`default_nettype none
module adcp_host (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [2:0] channel_in,
  input wire logic power_save_in,
  input wire logic cs_hold_in,
  input wire logic eoc_n_in,
  input wire logic [7:0] data_in,
  output logic convert_start_n_out,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic channel_sel_bit2_out,
  output logic channel_sel_bit1_out,
  output logic channel_sel_bit0_out,
  output logic busy_out,
  output logic [7:0] result_out,
  output logic [2:0] result_chan_out,
  output logic result_valid_out
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_WAKE = 7'h02,
    S_CONV = 7'h04,
    S_WAIT = 7'h08,
    S_READ = 7'h10,
    S_DONE = 7'h20,
    S_ACQ = 7'h40
  } adcp_state_t;

  typedef struct packed {
    adcp_state_t state;
    logic [adcp_pkg::CNT_W-1:0] cnt;
    logic conv_n;
    logic cs_n;
    logic rd_n;
    logic [adcp_pkg::CHAN_W-1:0] chan;
    logic [adcp_pkg::CHAN_W-1:0] conv_chan;
    logic [adcp_pkg::CHAN_W-1:0] next_chan;
    logic save;
    logic powered;
    logic busy;
    logic [adcp_pkg::DATA_W-1:0] result;
    logic [adcp_pkg::CHAN_W-1:0] result_chan;
    logic valid;
  } adcp_host_st_t;

  adcp_host_st_t st, next_st;
  logic eoc_fall;

  // Data-ready is the falling edge of end-of-conversion
  adcp_edge u_eoc_edge (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .level_in(eoc_n_in),
    .fall_out(eoc_fall)
  ); // R7

  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    // Chip select never depends on the channel lines
    next_st.cs_n = cs_hold_in ? 1'b0 : st.rd_n; // R5 R9
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    unique case (st.state)
      S_IDLE: begin
        next_st.busy = 1'b0;
        if (start_in) begin
          next_st.busy = 1'b1;
          next_st.next_chan = channel_in;
          next_st.save = power_save_in;
          if (st.powered) begin
            next_st.conv_n = 1'b0; // R10
            next_st.cnt = adcp_pkg::CNT_W'(adcp_pkg::CONV_SAMPLE_CYC);
            next_st.state = S_CONV;
          end else begin
            // Wake edge; on-chip reference needs the full power-up wait
            next_st.conv_n = 1'b1; // R13
            next_st.cnt = adcp_pkg::CNT_W'(adcp_pkg::PWRUP_CYC);
            next_st.state = S_WAKE;
          end
        end
      end
      S_WAKE: begin
        next_st.conv_n = 1'b1;
        if (st.cnt == '0) begin
          next_st.powered = 1'b1;
          next_st.conv_n = 1'b0; // R10
          next_st.cnt = adcp_pkg::CNT_W'(adcp_pkg::CONV_SAMPLE_CYC);
          next_st.state = S_CONV;
        end
      end
      S_CONV: begin
        next_st.conv_chan = st.chan;
        // Released early unless power-down is wanted at the end sample
        if (!st.save && st.cnt <= adcp_pkg::CNT_W'(adcp_pkg::CONV_SAMPLE_CYC
            - adcp_pkg::CONV_LOW_CYC)) begin
          next_st.conv_n = 1'b1; // R12
        end
        next_st.state = S_WAIT;
      end
      S_WAIT: begin
        if (!st.save && st.cnt <= adcp_pkg::CNT_W'(adcp_pkg::CONV_SAMPLE_CYC
            - adcp_pkg::CONV_LOW_CYC)) begin
          next_st.conv_n = 1'b1; // R12
        end
        if (eoc_fall) begin // R1
          // Read strobe falls now, presenting the next channel
          next_st.rd_n = 1'b0; // R4
          next_st.chan = st.next_chan; // R8 R11
          next_st.cnt = adcp_pkg::CNT_W'(adcp_pkg::READ_LOW_CYC);
          next_st.state = S_READ;
        end
      end
      S_READ: begin
        if (st.cnt == '0 && !st.cs_n) begin
          // Sample data before raising the strobe; end-of-conversion has already risen by then
          next_st.result = data_in; // R4 R14
          next_st.result_chan = st.conv_chan; // R11
          next_st.rd_n = 1'b1; // R3
          next_st.state = S_DONE;
        end
      end
      S_DONE: begin
        // Wait out the end-of-conversion rise before deciding power state
        if (st.cnt == '0 && eoc_n_in) begin // R2
          next_st.valid = 1'b1;
          if (st.save) begin
            next_st.powered = 1'b0; // R12
          end
          next_st.cnt = adcp_pkg::CNT_W'(adcp_pkg::ACQ_CYC);
          next_st.state = S_ACQ;
        end
      end
      S_ACQ: begin
        // With power-save set, the converter sleeps with the strobe low until the next wake edge
        if (st.cnt == '0) begin
          next_st.busy = 1'b0;
          next_st.state = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      // Convert strobe held high so the first start is a clean wake
      st <= '{state: S_IDLE, cnt: '0, conv_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1,
              chan: '0, conv_chan: '0, next_chan: '0, save: 1'b0, powered: 1'b0,
              busy: 1'b0, result: '0, result_chan: '0, valid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign convert_start_n_out = st.conv_n;
  assign cs_n_out = st.cs_n;
  assign rd_n_out = st.rd_n;
  assign channel_sel_bit2_out = st.chan[2];
  assign channel_sel_bit1_out = st.chan[1];
  assign channel_sel_bit0_out = st.chan[0];
  assign busy_out = st.busy;
  assign result_out = st.result;
  assign result_chan_out = st.result_chan;
  assign result_valid_out = st.valid;
endmodule // adcp_host
`default_nettype wire

// ==== adcp_pkg.sv ====
// Package of constants for the converter host port controller.
// Assumes a 20 MHz system clock; all times but EOC_MAX_NS become cycle counts here.
package adcp_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 3;
  // Longest end-of-conversion pulse the device produces
  localparam int EOC_MAX_NS = 110;
  // Converter gets back to work no later than this after the convert strobe falls
  localparam int CONV_SAMPLE_NS = 530;
  localparam int CONV_SAMPLE_CYC = CONV_SAMPLE_NS / CLK_PERIOD_NS;
  // Low time of the convert strobe when no power-down is wanted
  localparam int CONV_LOW_NS = 50;
  localparam int CONV_LOW_CYC = (CONV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Track-and-hold settle after a read before the next convert strobe
  localparam int ACQ_NS = 30;
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read strobe low time
  localparam int READ_LOW_NS = 100;
  localparam int READ_LOW_CYC = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Power-up wait after a wake edge, on-chip reference case
  localparam int PWRUP_NS = 25000;
  localparam int PWRUP_CYC = PWRUP_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
endpackage

// ==== adcp_edge.sv ====
// Falling edge detector for the end-of-conversion pin.
// Assumes the pin is already synchronous to clock_in.
`timescale 1ns/100ps
`default_nettype none
module adcp_edge (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic level_in,
  output logic fall_out
);
  typedef struct packed {
    logic prev;
    logic fall;
  } adcp_edge_st_t;
  adcp_edge_st_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.prev = level_in;
    next_st.fall = st.prev & ~level_in;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '{prev: 1'b1, fall: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign fall_out = st.fall;
endmodule // adcp_edge
`default_nettype wire

// ==== adcp_chk.sv ====
// Pin sequencing checks for the converter host port.
// Bound to adcp_host; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module adcp_chk (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cs_hold_in,
  input wire logic eoc_n_in,
  input wire logic convert_start_n_out,
  input wire logic cs_n_out,
  input wire logic rd_n_out,
  input wire logic busy_out,
  input wire logic [7:0] result_out,
  input wire logic result_valid_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  AST_CS_FOLLOWS: assert property (!cs_hold_in && $fell(rd_n_out) |=> $fell(cs_n_out))
    else $error("chip select late");
  AST_CS_HELD: assert property (cs_hold_in [*2] |=> !cs_n_out)
    else $error("chip select not held");
  AST_READ_ON_EOC: assert property (busy_out && $fell(eoc_n_in) |-> ##[1:3] !rd_n_out)
    else $error("no read after end of conversion");
  AST_RD_WIDTH: assert property ($fell(rd_n_out) |-> !rd_n_out [*3])
    else $error("read strobe too short");
  AST_VALID_ONE: assert property (result_valid_out |=> !result_valid_out)
    else $error("valid longer than one cycle");
  AST_IDLE_AFTER: assert property (result_valid_out |-> ##[1:2] !busy_out)
    else $error("busy stuck after result");
  // The result lands one cycle ahead of its valid pulse, later while end-of-conversion is low
  AST_RESULT_HOLD: assert property ($changed(result_out) |-> ##[0:3] result_valid_out)
    else $error("result changed without valid");
  AST_CONV_START: assert property ($rose(busy_out) |-> ##[0:502] !convert_start_n_out)
    else $error("no convert strobe");
endmodule // adcp_chk
`default_nettype wire

// ==== adcp_dev.sv ====
// Pin-level model of the eight-channel converter.
// Expects pins to change just after clock_in rises; a conversion takes 8 cycles.
`timescale 1ns/100ps
`default_nettype none
module adcp_dev (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic conv_n_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic [2:0] chan_in,
  output logic eoc_n_out,
  output logic [7:0] data_out
);
  logic conv_q, rd_q, pwr, low;
  logic [3:0] cnt;
  logic [2:0] next_ch, cur_ch;
  logic [7:0] res;
  // Released pins show the inverse, so a stale byte never passes
  assign data_out = (!cs_n_in && !rd_n_in) ? res : ~res;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      // Reset stands in for the power-up edge
      {conv_q, rd_q, eoc_n_out, pwr, low, cnt, next_ch, cur_ch, res} <= {5'h1F, 18'h0};
    end else begin
      conv_q <= conv_n_in;
      rd_q <= rd_n_in;
      if (conv_q && !conv_n_in && pwr) begin
        cnt <= 4'h8;
        cur_ch <= next_ch;
      end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        res <= 8'h50 + {5'h0, cur_ch};
        eoc_n_out <= 1'b0;
        low <= 1'b0;
      end else if (!eoc_n_out) begin
        low <= 1'b1;
        if (low || (rd_n_in && !rd_q)) eoc_n_out <= 1'b1;
        if ((low || (rd_n_in && !rd_q)) && !conv_n_in) pwr <= 1'b0;
      end
      if (conv_n_in && !conv_q) pwr <= 1'b1;
      if (rd_q && !rd_n_in) next_ch <= chan_in;
    end
  end
endmodule // adcp_dev
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the converter host port.
// Assumes adcp_dev stands in for the converter on the far side.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, power_save_in = 1'b0, cs_hold_in = 1'b0;
  logic [2:0] channel_in = 3'h0, prev = 3'h0, rchan;
  logic eoc_n, conv_n, cs_n, rd_n, b2, b1, b0, busy, valid;
  logic [7:0] data, result;
  int fails = 0, compares = 0;
  always #25 clock_in = ~clock_in;
  adcp_host i_dut (.clock_in(clock_in), .rst_in(rst_in), .start_in(start_in),
    .channel_in(channel_in), .power_save_in(power_save_in), .cs_hold_in(cs_hold_in),
    .eoc_n_in(eoc_n), .data_in(data), .convert_start_n_out(conv_n), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .channel_sel_bit2_out(b2), .channel_sel_bit1_out(b1),
    .channel_sel_bit0_out(b0), .busy_out(busy), .result_out(result),
    .result_chan_out(rchan), .result_valid_out(valid));
  adcp_dev i_dev (.clock_in(clock_in), .rst_in(rst_in), .conv_n_in(conv_n), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .chan_in({b2, b1, b0}), .eoc_n_out(eoc_n), .data_out(data));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Each result belongs to the channel sent with the previous start
  task automatic convert(input logic [2:0] ch, input logic ps, input logic hold);
    int n;
    n = 0;
    @(posedge clock_in);
    #5 {start_in, channel_in, power_save_in, cs_hold_in} = {1'b1, ch, ps, hold};
    @(posedge clock_in);
    #5 start_in = 1'b0;
    while (valid !== 1'b1 && n < 1500) begin
      @(posedge clock_in);
      #5 n++;
    end
    // A hung conversion counts as a mismatch
    if (valid !== 1'b1) fails++;
    check(result, 8'h50 + {5'h0, prev});
    check({5'h0, rchan}, {5'h0, prev});
    prev = ch;
    // Busy drops two edges after valid, once the acquisition count has run out
    repeat (2) @(posedge clock_in);
    #5 check({5'h0, busy, rd_n, cs_n}, {7'h01, !hold});
  endtask
  task automatic channel_hop;
    for (int i = 0; i < 8; i++) convert(i[2:0], 1'b0, i[0]);
  endtask
  task automatic power_cycle;
    convert(3'h5, 1'b1, 1'b0);
    check({7'h0, i_dev.pwr}, 8'h00);
    convert(3'h2, 1'b0, 1'b1);
    check({7'h0, i_dev.pwr}, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    #5 rst_in = 1'b0;
    convert(3'h3, 1'b0, 1'b0);
    channel_hop;
    power_cycle;
    tally_and_finish;
  end
  // Two wakes of 500 cycles dominate; this allows several times the expected run
  initial begin
    #400000;
    fails++;
    tally_and_finish;
  end
endmodule // tb
bind adcp_host adcp_chk i_chk (.clock_in(clock_in), .rst_in(rst_in), .cs_hold_in(cs_hold_in),
  .eoc_n_in(eoc_n_in), .convert_start_n_out(convert_start_n_out), .cs_n_out(cs_n_out),
  .rd_n_out(rd_n_out), .busy_out(busy_out), .result_out(result_out),
  .result_valid_out(result_valid_out));
`default_nettype wire
